// [inc/ast_map.vh]
// register map, field positions, reset values and timing counts of the serial channel
`ifndef AST_MAP_VH
`define AST_MAP_VH
// register byte offsets
`define AST_CTL0_OFF    8'h00
`define AST_OPT0_OFF    8'h04
`define AST_STR_OFF     8'h08
`define AST_RX_OFF      8'h0c
`define AST_TX_OFF      8'h10
`define AST_BRG_OFF     8'h14
`define AST_EVT_OFF     8'h18
// primary control fields
`define AST_CTL0_PWR    7
`define AST_CTL0_TXE    6
`define AST_CTL0_RXE    5
`define AST_CTL0_DIR    4
`define AST_CTL0_PS1    3
`define AST_CTL0_PS0    2
`define AST_CTL0_CL     1
`define AST_CTL0_SL     0
`define AST_CTL0_RST    8'h01
// option control fields
`define AST_OPT0_TDL    1
`define AST_OPT0_RDL    0
`define AST_OPT0_RST    8'h14
// status fields
`define AST_STR_TSF     7
`define AST_STR_PE      2
`define AST_STR_FE      1
`define AST_STR_OVE     0
// data register reset values
`define AST_TX_RST      8'hff
`define AST_RX_RST      8'hff
// baud tick divider: base clocks per bit
`define AST_BRG_RST     16'h0010
// parity modes
`define AST_PAR_NONE    2'h0
`define AST_PAR_ZERO    2'h1
`define AST_PAR_ODD     2'h2
`define AST_PAR_EVEN    2'h3
// axi responses
`define AST_RESP_OKAY   2'h0
`define AST_RESP_SLVERR 2'h2
`endif

// [hw/ast_rx_filter.v]
// receive input synchroniser and two-sample noise filter
`timescale 1ns/1ps
module ast_rx_filter (
   // clock and reset
   input  wire aclk,
   input  wire aresetn,
   // raw pin and filtered level
   input  wire pin_in,
   input  wire invert,
   output reg  level_r
);
   reg sync1_r;
   reg sync2_r;
   reg sync3_r;

   // three stages; the level moves only when stages two and three agree, so one-clock glitches die here
   always @(posedge aclk) begin
      if (!aresetn) begin
         sync1_r <= 1'b1;
         sync2_r <= 1'b1;
         sync3_r <= 1'b1;
         level_r <= 1'b1;
      end else begin
         sync1_r <= pin_in;
         sync2_r <= sync1_r;
         sync3_r <= sync2_r;
         if (sync2_r == sync3_r)
            level_r <= sync3_r ^ invert;
      end
   end
endmodule

// [hw/ast_serial_channel.v]
// asynchronous serial transceiver channel with axi4-lite register slave
// What this block does
// - serial output idles high once the power bit is set
// - writing transmit data while transmit enabled starts a framed transmission
// - load shift register, pulse buffer-empty request, then shift the frame out
// - power then receive enable puts receiver into start-bit wait
// - falling edge starts sampling; start accepted only if low at mid-bit
// - stop bit copies shift register to receive data; overrun discards data
// - parity or framing errors still run to first stop bit, then error request
// - receiver checks only one stop bit
// - receive-complete and receive-error requests never raised together
// - frame format chosen by length, parity, stop length and bit order
// - parity, framing and overrun flags set on their causes
// - even parity makes total ones even; odd total is an error
// - odd parity makes total ones odd; even total is an error
// - zero parity sends zero and never checks
// - no parity sends none, expects none, never errors
// - input filtered; level changes after two equal samples
// - internal receive path lags the pin by four clocks
// - invert bit complements the transmit waveform
// - seven-bit data lands in bits 6..0 or 7..1 by bit order
// - error flags cleared by writing zero or when power or receive off
//
// Implementation choices: the address map and register access over AXI4-Lite.
`timescale 1ns/1ps
`include "ast_map.vh"
module ast_serial_channel (
   // clock and reset
   input  wire        aclk,
   input  wire        aresetn,
   // axi4-lite write address
   input  wire [7:0]  s_axi_awaddr,
   input  wire        s_axi_awvalid,
   output reg         s_axi_awready,
   // axi4-lite write data
   input  wire [31:0] s_axi_wdata,
   input  wire [3:0]  s_axi_wstrb,
   input  wire        s_axi_wvalid,
   output reg         s_axi_wready,
   // axi4-lite write response
   output reg  [1:0]  s_axi_bresp,
   output reg         s_axi_bvalid,
   input  wire        s_axi_bready,
   // axi4-lite read address
   input  wire [7:0]  s_axi_araddr,
   input  wire        s_axi_arvalid,
   output reg         s_axi_arready,
   // axi4-lite read data
   output reg  [31:0] s_axi_rdata,
   output reg  [1:0]  s_axi_rresp,
   output reg         s_axi_rvalid,
   input  wire        s_axi_rready,
   // serial pins
   input  wire        serial_in_pin,
   output reg         serial_out_pin,
   // request pulses
   output reg         tx_buffer_empty_request,
   output reg         rx_complete_request,
   output reg         rx_error_request
);
   localparam TX_IDLE = 3'b001;
   localparam TX_LOAD = 3'b010;
   localparam TX_SHIFT = 3'b100;
   localparam RX_WAIT = 3'b001;
   localparam RX_START = 3'b010;
   localparam RX_DATA = 3'b100;

   reg [7:0]  ctl0_r;
   reg [7:0]  opt0_r;
   reg [15:0] brg_r;
   reg [7:0]  txd_r;
   reg [7:0]  rxd_r;
   reg        tx_full_r;
   reg        tsf_r;
   reg        pe_r;
   reg        fe_r;
   reg        ove_r;
   reg        rx_unread_r;
   reg [15:0] tx_div_r;
   reg [2:0]  tx_st_r;
   reg [10:0] tx_sh_r;
   reg [3:0]  tx_cnt_r;
   reg        tx_line_r;
   reg [2:0]  rx_st_r;
   reg [15:0] rx_div_r;
   reg [3:0]  rx_cnt_r;
   reg [8:0]  rx_sh_r;
   reg        rx_prev_r;
   reg [7:0]  aw_addr_r;
   reg        aw_have_r;
   reg [31:0] w_data_r;
   reg [3:0]  w_strb_r;
   reg        w_have_r;
   wire       rx_level;

   wire pwr = ctl0_r[`AST_CTL0_PWR];
   wire txe = ctl0_r[`AST_CTL0_TXE];
   wire rxe = ctl0_r[`AST_CTL0_RXE];
   wire msb_first = ctl0_r[`AST_CTL0_DIR];
   wire [1:0] pmode = ctl0_r[`AST_CTL0_PS1:`AST_CTL0_PS0];
   wire len8 = ctl0_r[`AST_CTL0_CL];
   wire rx_on = pwr & rxe;

   // register index decode, shared by reads and writes
   function [6:0] dec;
      input [7:0] a;
      begin
         dec = {a == `AST_EVT_OFF, a == `AST_BRG_OFF, a == `AST_TX_OFF, a == `AST_RX_OFF,
                a == `AST_STR_OFF, a == `AST_OPT0_OFF, a == `AST_CTL0_OFF};
      end
   endfunction

   // even parity of the active character bits
   function par8;
      input [7:0] d;
      input       l8;
      begin
         par8 = ^d[6:0] ^ (l8 & d[7]);
      end
   endfunction

   ast_rx_filter u_filt (
      .aclk    (aclk),
      .aresetn (aresetn),
      .pin_in  (serial_in_pin),
      .invert  (opt0_r[`AST_OPT0_RDL]),
      .level_r (rx_level)
   );

   // write channel: address and data accepted in either order, response after both
   wire       wr_go = aw_have_r & w_have_r & ~s_axi_bvalid;
   wire [6:0] wsel = dec(aw_addr_r);
   wire       wr_b0 = wr_go & w_strb_r[0];
   wire       tx_wr = wr_b0 & wsel[4];
   wire       str_wr = wr_b0 & wsel[2];
   wire       rd_go = s_axi_arvalid & s_axi_arready;
   wire [6:0] rsel = dec(s_axi_araddr);
   wire       rx_rd = rd_go & rsel[3];

   always @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_awready <= 1'b1;
         s_axi_wready <= 1'b1;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= `AST_RESP_OKAY;
         aw_have_r <= 1'b0;
         w_have_r <= 1'b0;
         aw_addr_r <= 8'h00;
         w_data_r <= 32'h00000000;
         w_strb_r <= 4'h0;
      end else begin
         if (s_axi_awvalid & s_axi_awready) begin
            aw_addr_r <= s_axi_awaddr;
            aw_have_r <= 1'b1;
            s_axi_awready <= 1'b0;
         end
         if (s_axi_wvalid & s_axi_wready) begin
            w_data_r <= s_axi_wdata;
            w_strb_r <= s_axi_wstrb;
            w_have_r <= 1'b1;
            s_axi_wready <= 1'b0;
         end
         if (wr_go) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= (wsel == 7'h00) ? `AST_RESP_SLVERR : `AST_RESP_OKAY;
            aw_have_r <= 1'b0;
            w_have_r <= 1'b0;
         end
         if (s_axi_bvalid & s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
            s_axi_awready <= 1'b1;
            s_axi_wready <= 1'b1;
         end
      end
   end

   // read channel: one read at a time, data one cycle after the address
   always @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_arready <= 1'b1;
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= 32'h00000000;
         s_axi_rresp <= `AST_RESP_OKAY;
      end else if (rd_go) begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid <= 1'b1;
         s_axi_rresp <= (rsel == 7'h00) ? `AST_RESP_SLVERR : `AST_RESP_OKAY;
         case (1'b1)
            rsel[0]: s_axi_rdata <= {24'h000000, ctl0_r};
            rsel[1]: s_axi_rdata <= {24'h000000, opt0_r};
            rsel[2]: s_axi_rdata <= {24'h000000, tsf_r, 4'h0, pe_r, fe_r, ove_r};
            rsel[3]: s_axi_rdata <= {24'h000000, rxd_r};
            rsel[4]: s_axi_rdata <= {24'h000000, txd_r};
            rsel[5]: s_axi_rdata <= {16'h0000, brg_r};
            rsel[6]: s_axi_rdata <= {29'h00000000, tx_full_r, rx_unread_r, rx_level};
            default: s_axi_rdata <= 32'h00000000;
         endcase
      end else if (s_axi_rvalid & s_axi_rready) begin
         s_axi_rvalid <= 1'b0;
         s_axi_arready <= 1'b1;
      end
   end

   // control registers; low byte lane only, except the divider high byte on lane one
   always @(posedge aclk) begin
      if (!aresetn) begin
         ctl0_r <= `AST_CTL0_RST;
         opt0_r <= `AST_OPT0_RST;
         brg_r <= `AST_BRG_RST;
      end else begin
         if (wr_b0 & wsel[0])
            ctl0_r <= w_data_r[7:0];
         if (wr_b0 & wsel[1])
            opt0_r <= w_data_r[7:0];
         if (wr_go & wsel[5]) begin
            if (w_strb_r[0])
               brg_r[7:0] <= w_data_r[7:0];
            if (w_strb_r[1])
               brg_r[15:8] <= w_data_r[15:8];
         end
      end
   end

   // transmitter: baud tick from divider, frame built at load time
   wire       tx_tick = (tx_div_r == 16'h0001);
   wire [7:0] tx_ord = msb_first ? (len8 ? {txd_r[0], txd_r[1], txd_r[2], txd_r[3], txd_r[4],
                        txd_r[5], txd_r[6], txd_r[7]} : {1'b0, txd_r[0], txd_r[1], txd_r[2],
                        txd_r[3], txd_r[4], txd_r[5], txd_r[6]}) : txd_r;
   wire       tx_pbit = (pmode == `AST_PAR_EVEN) ? par8(txd_r, len8) :
                        (pmode == `AST_PAR_ODD) ? ~par8(txd_r, len8) : 1'b0;
   wire [3:0] tx_bits = 4'd2 + (len8 ? 4'd8 : 4'd7) + ((pmode == `AST_PAR_NONE) ? 4'd0 : 4'd1)
                        + (ctl0_r[`AST_CTL0_SL] ? 4'd1 : 4'd0);
   wire [10:0] tx_frame = (pmode == `AST_PAR_NONE) ?
                          (len8 ? {2'b11, tx_ord, 1'b0} : {3'b111, tx_ord[6:0], 1'b0}) :
                          (len8 ? {1'b1, tx_pbit, tx_ord, 1'b0} : {2'b11, tx_pbit, tx_ord[6:0], 1'b0});

   always @(posedge aclk) begin
      if (!aresetn || !pwr || !txe) begin
         tx_st_r <= TX_IDLE;
         tx_div_r <= 16'h0000;
         tx_sh_r <= 11'h7ff;
         tx_cnt_r <= 4'h0;
         tx_line_r <= 1'b1;
         tx_full_r <= 1'b0;
         tsf_r <= 1'b0;
         tx_buffer_empty_request <= 1'b0;
      end else begin
         tx_buffer_empty_request <= 1'b0;
         tx_div_r <= tx_tick ? brg_r : tx_div_r - 16'h0001;
         if (tx_wr) begin
            tx_full_r <= 1'b1;
            tsf_r <= 1'b1;
         end
         case (tx_st_r)
            TX_IDLE: begin
               if (tx_full_r)
                  tx_st_r <= TX_LOAD;
            end
            TX_LOAD: begin
               tx_sh_r <= tx_frame;
               tx_cnt_r <= tx_bits;
               tx_full_r <= tx_wr;
               tx_buffer_empty_request <= 1'b1;
               tx_div_r <= brg_r;
               tx_line_r <= 1'b0;
               tx_st_r <= TX_SHIFT;
            end
            TX_SHIFT: begin
               if (tx_tick) begin
                  tx_sh_r <= {1'b1, tx_sh_r[10:1]};
                  tx_line_r <= tx_sh_r[1];
                  tx_cnt_r <= tx_cnt_r - 4'h1;
                  if (tx_cnt_r == 4'h1) begin
                     tx_line_r <= 1'b1;
                     tx_st_r <= TX_IDLE;
                     if (!tx_full_r && !tx_wr)
                        tsf_r <= 1'b0;
                  end
               end
            end
            default: tx_st_r <= TX_IDLE;
         endcase
      end
   end

   // pin driver: idle high with power on, complemented when asked
   always @(posedge aclk) begin
      if (!aresetn)
         serial_out_pin <= 1'b1;
      else
         serial_out_pin <= (pwr ? tx_line_r : 1'b1) ^ opt0_r[`AST_OPT0_TDL];
   end

   // transmit data register
   always @(posedge aclk) begin
      if (!aresetn)
         txd_r <= `AST_TX_RST;
      else if (tx_wr)
         txd_r <= w_data_r[7:0];
   end

   // receiver: frame length counts data, parity and one stop only
   wire       rx_half = (rx_div_r == {1'b0, brg_r[15:1]});
   wire       rx_tick = (rx_div_r == 16'h0001);
   wire [3:0] rx_need = (len8 ? 4'd8 : 4'd7) + ((pmode == `AST_PAR_NONE) ? 4'd0 : 4'd1) + 4'd1;
   wire [8:0] rx_al = (pmode == `AST_PAR_NONE) ? {rx_sh_r[8], rx_sh_r[8:1]} : rx_sh_r;
   wire [7:0] rx_raw = len8 ? rx_al[7:0] : {1'b0, rx_al[7:1]};
   wire       rx_pin = len8 ? rx_al[8] : rx_al[8];
   wire       rx_pbad = ((pmode == `AST_PAR_EVEN) & (par8(rx_raw, len8) ^ rx_pin)) |
                        ((pmode == `AST_PAR_ODD) & ~(par8(rx_raw, len8) ^ rx_pin));
   wire [7:0] rx_rev = {rx_raw[0], rx_raw[1], rx_raw[2], rx_raw[3], rx_raw[4], rx_raw[5], rx_raw[6], rx_raw[7]};
   // reversal alone lands seven-bit data in bits 7..1, since the unused raw top bit is zero
   wire [7:0] rx_byte = msb_first ? rx_rev : rx_raw;
   // a read in the same cycle as a frame end frees the register, so no overrun then
   wire       rx_held = rx_unread_r & ~rx_rd;

   always @(posedge aclk) begin
      if (!aresetn || !rx_on) begin
         rx_st_r <= RX_WAIT;
         rx_div_r <= 16'h0000;
         rx_cnt_r <= 4'h0;
         rx_sh_r <= 9'h000;
         rx_prev_r <= 1'b1;
         rx_complete_request <= 1'b0;
         rx_error_request <= 1'b0;
         pe_r <= 1'b0;
         fe_r <= 1'b0;
         ove_r <= 1'b0;
         rx_unread_r <= 1'b0;
      end else begin
         rx_complete_request <= 1'b0;
         rx_error_request <= 1'b0;
         rx_prev_r <= rx_level;
         rx_div_r <= rx_tick ? brg_r : rx_div_r - 16'h0001;
         if (rx_rd)
            rx_unread_r <= 1'b0;
         // written zeros clear flags; hardware sets below override
         if (str_wr) begin
            pe_r <= pe_r & w_data_r[`AST_STR_PE];
            fe_r <= fe_r & w_data_r[`AST_STR_FE];
            ove_r <= ove_r & w_data_r[`AST_STR_OVE];
         end
         case (rx_st_r)
            RX_WAIT: begin
               if (rx_prev_r && !rx_level) begin
                  rx_div_r <= brg_r;
                  rx_st_r <= RX_START;
               end
            end
            RX_START: begin
               if (rx_half) begin
                  if (rx_level) begin
                     rx_st_r <= RX_WAIT;
                  end else begin
                     rx_div_r <= brg_r;
                     rx_cnt_r <= rx_need;
                     rx_st_r <= RX_DATA;
                  end
               end
            end
            RX_DATA: begin
               if (rx_tick) begin
                  rx_cnt_r <= rx_cnt_r - 4'h1;
                  if (rx_cnt_r != 4'h1) begin
                     rx_sh_r <= {rx_level, rx_sh_r[8:1]};
                  end else begin
                     rx_st_r <= RX_WAIT;
                     if (rx_pbad)
                        pe_r <= 1'b1;
                     if (!rx_level)
                        fe_r <= 1'b1;
                     if (rx_held)
                        ove_r <= 1'b1;
                     else
                        rx_unread_r <= 1'b1;
                     if (rx_pbad || !rx_level || rx_held)
                        rx_error_request <= 1'b1;
                     else
                        rx_complete_request <= 1'b1;
                  end
               end
            end
            default: rx_st_r <= RX_WAIT;
         endcase
      end
   end

   // receive data register; overrun leaves it untouched, power off sets all ones
   always @(posedge aclk) begin
      if (!aresetn || !pwr)
         rxd_r <= `AST_RX_RST;
      else if (rx_on && rx_st_r == RX_DATA && rx_tick && rx_cnt_r == 4'h1 && !rx_held)
         rxd_r <= rx_byte;
   end
endmodule

// [test/ast_serial_channel_assertions.sv]
// port-level checker for the serial channel
`timescale 1ns/1ps
module ast_chk (
   // clock and reset
   input wire        aclk,
   input wire        aresetn,
   // bus handshakes
   input wire        s_axi_awvalid,
   input wire        s_axi_awready,
   input wire        s_axi_wvalid,
   input wire        s_axi_wready,
   input wire        s_axi_bvalid,
   input wire        s_axi_arvalid,
   input wire        s_axi_arready,
   input wire        s_axi_rvalid,
   input wire        s_axi_rready,
   input wire [31:0] s_axi_rdata,
   // serial side
   input wire        serial_in_pin,
   input wire        serial_out_pin,
   input wire        tx_buffer_empty_request,
   input wire        rx_complete_request,
   input wire        rx_error_request
);
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);
   // write taken with both channels at once, as the bench offers them
   sequence s_wr_taken;
      s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
   endsequence
   sequence s_b_answer;
      ##[1:3] s_axi_bvalid;
   endsequence
   property p_idle_high;
      $rose(aresetn) |-> serial_out_pin;
   endproperty
   property p_tbe_start;
      tx_buffer_empty_request |-> ##[0:3] $changed(serial_out_pin);
   endproperty
   property p_tbe_pulse;
      tx_buffer_empty_request |=> !tx_buffer_empty_request;
   endproperty
   property p_rx_excl;
      !(rx_complete_request && rx_error_request);
   endproperty
   // internal sample lags the pin by four clocks; looking back four still lands in the stop bit
   property p_rx_stop;
      rx_complete_request |-> $past(serial_in_pin, 4);
   endproperty
   property p_b_answer;
      s_wr_taken |-> s_b_answer;
   endproperty
   property p_r_answer;
      s_axi_arvalid && s_axi_arready |=> s_axi_rvalid;
   endproperty
   property p_r_hold;
      s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
   endproperty
   a_idle_high: assert property (p_idle_high) else $error("output not idle high");
   a_tbe_start: assert property (p_tbe_start) else $error("no start bit");
   a_tbe_pulse: assert property (p_tbe_pulse) else $error("empty request too long");
   a_rx_excl: assert property (p_rx_excl) else $error("both receive requests");
   a_rx_stop: assert property (p_rx_stop) else $error("complete without stop");
   a_b_answer: assert property (p_b_answer) else $error("no write response");
   a_r_answer: assert property (p_r_answer) else $error("no read data");
   a_r_hold: assert property (p_r_hold) else $error("read data dropped");
endmodule
bind ast_serial_channel ast_chk u_chk (.aclk(aclk), .aresetn(aresetn), .s_axi_awvalid(s_axi_awvalid),
   .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
   .s_axi_bvalid(s_axi_bvalid), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
   .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .s_axi_rdata(s_axi_rdata),
   .serial_in_pin(serial_in_pin), .serial_out_pin(serial_out_pin),
   .tx_buffer_empty_request(tx_buffer_empty_request), .rx_complete_request(rx_complete_request),
   .rx_error_request(rx_error_request));

// [test/ast_remote_model.sv]
// remote serial end: frame sender and frame capturer
`timescale 1ns/1ps
module ast_remote_model (
   // clock
   input wire aclk,
   // serial lines seen from the remote end
   input wire line_in,
   output reg line_out
);
   int        bt = 16;
   int        rx_n = 10;
   int        cap_cnt = 0;
   reg [11:0] cap_r;
   reg [11:0] acc;
   initial line_out = 1'b1;
   // start bit, then n bits lsb first, then one idle bit at the pulled-up level
   task send(input [11:0] f, input int n);
      line_out <= 1'b0;
      repeat (bt) @(posedge aclk);
      for (int i = 0; i < n; i++) begin
         line_out <= f[i];
         repeat (bt) @(posedge aclk);
      end
      line_out <= 1'b1;
      repeat (bt) @(posedge aclk);
   endtask
   // mid-bit capture from the start edge; start bit itself is not kept
   always begin
      @(negedge line_in);
      acc = 12'h000;
      repeat (bt / 2) @(posedge aclk);
      for (int i = 0; i < rx_n; i++) begin
         repeat (bt) @(posedge aclk);
         acc[i] = line_in;
      end
      cap_r = acc;
      cap_cnt++;
   end
endmodule

// [test/tb_ast_serial_channel.sv]
// self-checking bench for the serial channel
`timescale 1ns/1ps
`include "ast_map.vh"
module tb_ast_serial_channel;
   reg        aclk, aresetn;
   reg [7:0]  s_axi_awaddr, s_axi_araddr;
   reg [31:0] s_axi_wdata;
   reg [3:0]  s_axi_wstrb;
   reg        s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
   wire       s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   wire [1:0] s_axi_bresp, s_axi_rresp;
   wire [31:0] s_axi_rdata;
   wire       serial_in_pin, serial_out_pin, tx_buffer_empty_request, rx_complete_request, rx_error_request;
   int        bad_count = 0, samples_checked = 0, n_tbe = 0, n_ok = 0, n_err = 0, c, t, k;
   reg [31:0] rd;
   reg [1:0]  rs;
   reg [39:0] e;
   // ctl0, frame, frame bits, status, receive data
   reg [39:0] rxt [0:8] = '{{8'hee,12'h2a6,4'd10,8'h00,8'ha6}, {8'hee,12'h3a6,4'd10,8'h04,8'h00},
      {8'hea,12'h2a6,4'd10,8'h04,8'h00}, {8'hea,12'h3a6,4'd10,8'h00,8'ha6}, {8'he6,12'h3a6,4'd10,8'h00,8'ha6},
      {8'he2,12'h1a6,4'd9,8'h00,8'ha6}, {8'hee,12'h0a6,4'd10,8'h02,8'h00}, {8'ha0,12'h0d3,4'd8,8'h00,8'h53},
      {8'hb0,12'h0e5,4'd8,8'h00,8'ha6}};
   ast_serial_channel DUT (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(s_axi_awaddr),
      .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
      .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
      .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
      .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
      .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
      .s_axi_rready(s_axi_rready), .serial_in_pin(serial_in_pin), .serial_out_pin(serial_out_pin),
      .tx_buffer_empty_request(tx_buffer_empty_request), .rx_complete_request(rx_complete_request),
      .rx_error_request(rx_error_request));
   ast_remote_model u_far (.aclk(aclk), .line_in(serial_out_pin), .line_out(serial_in_pin));
   initial begin
      aclk = 1'b0;
      forever #5 aclk = ~aclk;
   end
   // request pulses last one cycle, so count them as they pass
   always @(posedge aclk) begin
      if (tx_buffer_empty_request === 1'b1) n_tbe++;
      if (rx_complete_request === 1'b1) n_ok++;
      if (rx_error_request === 1'b1) n_err++;
   end
   task chk_data(input [31:0] got, input [31:0] exp);
      samples_checked++;
      if (got !== exp) begin
         bad_count++;
         $display("unexpected at %0t: value %h, wanted %h", $time, got, exp);
      end
   endtask
   task chk_resp(input [1:0] got, input [1:0] exp);
      samples_checked++;
      if (got !== exp) begin
         bad_count++;
         $display("unexpected at %0t: response %h, wanted %h", $time, got, exp);
      end
   endtask
   // one edge of spacing at the end keeps the next call off this time step
   task axi_wr(input [7:0] a, input [31:0] d);
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_wstrb <= 4'hf;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      do begin
         @(posedge aclk);
         if (s_axi_awready) s_axi_awvalid <= 1'b0;
         if (s_axi_wready) s_axi_wvalid <= 1'b0;
      end while (s_axi_bvalid !== 1'b1);
      rs = s_axi_bresp;
      s_axi_bready <= 1'b0;
      @(posedge aclk);
   endtask
   task axi_rd(input [7:0] a);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      do begin
         @(posedge aclk);
         if (s_axi_arready) s_axi_arvalid <= 1'b0;
      end while (s_axi_rvalid !== 1'b1);
      rd = s_axi_rdata;
      rs = s_axi_rresp;
      s_axi_rready <= 1'b0;
      @(posedge aclk);
   endtask
   task rd_chk(input [7:0] a, input [31:0] exp);
      axi_rd(a);
      chk_resp(rs, `AST_RESP_OKAY);
      chk_data(rd, exp);
   endtask
   task report_and_stop;
      $display("checks %0d, mismatches %0d", samples_checked, bad_count);
      if (bad_count == 0 && samples_checked > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask
   // watchdog well beyond the expected few thousand cycles
   initial begin
      repeat (20000) @(posedge aclk);
      bad_count++;
      $display("unexpected at %0t: watchdog expired", $time);
      report_and_stop;
   end
   initial begin
      {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 6'h00;
      {s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_wstrb} = 52'h0;
      repeat (16) @(posedge aclk);
      aresetn <= 1'b1;
      @(posedge aclk);
      rd_chk(`AST_CTL0_OFF, 32'h01);
      rd_chk(`AST_OPT0_OFF, 32'h14);
      rd_chk(`AST_TX_OFF, 32'hff);
      rd_chk(`AST_RX_OFF, 32'hff);
      axi_rd(8'h40);
      chk_resp(rs, `AST_RESP_SLVERR);
      axi_wr(8'h40, 32'h0);
      chk_resp(rs, `AST_RESP_SLVERR);
      axi_wr(`AST_CTL0_OFF, 32'h80);
      chk_data(serial_out_pin, 1);
      $display("test reset values done");
      // every parity mode on a byte with an odd count of ones
      for (int m = 0; m < 4; m++) begin
         axi_wr(`AST_CTL0_OFF, 32'h0);
         axi_wr(`AST_CTL0_OFF, 32'he2 | (m << 2));
         u_far.rx_n = (m == 0) ? 9 : 10;
         c = u_far.cap_cnt;
         t = n_tbe;
         axi_wr(`AST_TX_OFF, 32'h5b);
         for (k = 0; k < 400 && u_far.cap_cnt == c; k++) @(posedge aclk);
         chk_data(u_far.cap_r, (m == 0) ? 12'h15b : {3'b001, m == 3, 8'h5b});
         chk_data(n_tbe - t, 1);
         repeat (40) @(posedge aclk);
         rd_chk(`AST_STR_OFF, 32'h0);
      end
      // back to back: second byte written while the first is still shifting
      c = u_far.cap_cnt;
      t = n_tbe;
      axi_wr(`AST_TX_OFF, 32'h5b);
      for (k = 0; k < 400 && n_tbe == t; k++) @(posedge aclk);
      axi_wr(`AST_TX_OFF, 32'ha6);
      for (k = 0; k < 800 && u_far.cap_cnt < c + 2; k++) @(posedge aclk);
      chk_data(u_far.cap_r, 12'h2a6);
      chk_data(n_tbe - t, 2);
      repeat (40) @(posedge aclk);
      rd_chk(`AST_STR_OFF, 32'h0);
      $display("test transmit done");
      for (int i = 0; i < 9; i++) begin
         e = rxt[i];
         axi_wr(`AST_CTL0_OFF, 32'h0);
         axi_wr(`AST_CTL0_OFF, {24'h0, e[39:32]});
         c = n_ok;
         t = n_err;
         u_far.send(e[31:20], e[19:16]);
         repeat (8) @(posedge aclk);
         chk_data(n_ok - c, e[15:8] == 8'h00);
         chk_data(n_err - t, e[15:8] != 8'h00);
         rd_chk(`AST_STR_OFF, e[15:8]);
         axi_wr(`AST_STR_OFF, 32'h7);
         rd_chk(`AST_STR_OFF, e[15:8]);
         axi_rd(`AST_RX_OFF);
         if (e[15:8] == 8'h00) chk_data(rd, e[7:0]);
      end
      $display("test receive done");
      // back to eight bits, even parity, lsb first for the overrun frames
      axi_wr(`AST_CTL0_OFF, 32'h0);
      axi_wr(`AST_CTL0_OFF, 32'hee);
      // second frame left unread overruns; first byte must survive
      u_far.send(12'h2a6, 10);
      c = n_err;
      u_far.send(12'h211, 10);
      repeat (8) @(posedge aclk);
      chk_data(n_err - c, 1);
      rd_chk(`AST_STR_OFF, 32'h1);
      rd_chk(`AST_RX_OFF, 32'ha6);
      axi_wr(`AST_STR_OFF, 32'h0);
      rd_chk(`AST_STR_OFF, 32'h0);
      axi_wr(`AST_CTL0_OFF, 32'h0);
      axi_wr(`AST_CTL0_OFF, 32'h80);
      axi_wr(`AST_OPT0_OFF, 32'h16);
      repeat (2) @(posedge aclk);
      chk_data(serial_out_pin, 0);
      $display("test overrun and invert done");
      report_and_stop;
   end
endmodule
